// ===== tsop_pkg.sv
package tsop_pkg;

  // Core clock and tone timing
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned TONE_HZ       = 22_000;
  localparam int unsigned TONE_HALF_CYC = CLK_HZ / (2 * TONE_HZ);
  localparam int          TONE_CNT_W    = 11;
  localparam logic [TONE_CNT_W-1:0] TONE_RELOAD = TONE_CNT_W'(TONE_HALF_CYC - 1);
  localparam logic [TONE_CNT_W-1:0] TONE_ZERO   = 11'h000;

  // Stream layout
  localparam int          BYTE_W         = 8;
  localparam int          PARITY_BYTES   = 16;
  localparam logic [7:0]  BLOCK_LEN_LONG = 8'hBC;
  localparam logic [7:0]  BLOCK_LEN_SHORT = 8'h90;
  localparam logic [7:0]  TEI_BYTE_IDX   = 8'h01;
  localparam int          TEI_BIT        = 7;
  localparam logic [7:0]  IDX_ZERO       = 8'h00;
  localparam logic [7:0]  IDX_ONE        = 8'h01;
  localparam logic [2:0]  BIT_ZERO       = 3'h0;
  localparam logic [2:0]  BIT_ONE        = 3'h1;
  localparam logic [2:0]  BIT_LAST       = 3'h7;

  // Symbol counts per core cycle
  localparam logic [1:0]  SYM_NONE = 2'h0;
  localparam logic [1:0]  SYM_TWO  = 2'h2;

  // Link configuration bits, index into the synchronised vector
  localparam int          CFG_W    = 3;
  localparam int          CFG_FALL = 0;
  localparam int          CFG_SER  = 1;
  localparam int          CFG_SERV = 2;

  // Test select codes
  localparam logic [7:0]  TSEL_STREAM = 8'h01;
  localparam logic [7:0]  TSEL_SYNC   = 8'h02;
  localparam logic [7:0]  TSEL_LEVELS = 8'h03;
  localparam logic [15:0] TEST_IDLE   = 16'h0000;

  typedef enum logic [1:0] {
    LS_LAUNCH = 2'b01,
    LS_HOLD   = 2'b10
  } tsop_slot_t;

  typedef struct packed {
    logic             first;
    logic             parity;
    logic             uncorr;
    logic [BYTE_W-1:0] data;
  } tsop_word_t;

endpackage

// ===== tsop_sd_if.sv
interface tsop_sd_if #(parameter int W = 8);
  logic [W-1:0] level;
  logic         bit_out;
  modport src (output level, input bit_out);
  modport dac (input level, output bit_out);
endinterface

// ===== tsop_sdm.sv
module tsop_sdm
  import tsop_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Level in, density out
  tsop_sd_if.dac    sd
);

  typedef struct packed {
    logic [W-1:0] acc;
    logic         bit_out;
  } tsop_sdm_st_t;

  tsop_sdm_st_t st_ff;
  tsop_sdm_st_t nxt_st;
  logic [W:0]   sum;

  // First-order modulator: carry density equals level / 2^W
  always_comb begin
    sum            = {1'b0, st_ff.acc} + {1'b0, sd.level};
    nxt_st.acc     = sum[W-1:0];
    nxt_st.bit_out = sum[W];
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sd.bit_out = st_ff.bit_out;

endmodule // tsop_sdm

// ===== tsop_top.sv
module tsop_top
  import tsop_pkg::*;
(
  // Core clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_sys_rst,
  // Link clock
  input  wire logic              i_link_clk,
  // Decoded byte stream from block decoder
  input  wire logic [BYTE_W-1:0] i_dec_byte,
  input  wire logic              i_dec_valid,
  input  wire logic              i_dec_first,
  input  wire logic              i_dec_parity,
  input  wire logic              i_dec_uncorr,
  output logic                   o_dec_ready,
  // Link configuration
  input  wire logic              i_cfg_falling,
  input  wire logic              i_cfg_serial,
  input  wire logic              i_cfg_serial_valid,
  // Sync status from upstream stages
  input  wire logic              i_carrier_locked,
  input  wire logic              i_node_synced,
  input  wire logic              i_frame_locked,
  input  wire logic [1:0]        i_sym_count,
  input  wire logic              i_trellis_bit,
  input  wire logic              i_trellis_valid,
  // Analog controls and test
  input  wire logic [7:0]        i_dac_level,
  input  wire logic [7:0]        i_gain_level,
  input  wire logic              i_tone_enable,
  input  wire logic [7:0]        i_test_select,
  // Transport stream link
  output logic [BYTE_W-1:0]      o_ts_data,
  output logic                   o_ts_byte_clk,
  output logic                   o_ts_valid,
  output logic                   o_ts_block_start,
  output logic                   o_ts_byte_strobe,
  output logic                   o_ts_block_error,
  // Status and auxiliary outputs
  output logic                   o_carrier_phase_locked,
  output logic                   o_trellis_node_synced,
  output logic                   o_sync_done,
  output logic                   o_symbol_tick,
  output logic                   o_trellis_serial_out,
  output logic                   o_trellis_serial_strobe,
  output logic                   o_density_dac_out,
  output logic                   o_gain_control_bit,
  output logic                   o_dish_tone_out,
  output logic [15:0]            o_test,
  output logic                   o_clk_copy
);

  typedef struct packed {
    logic [TONE_CNT_W-1:0] tone_cnt;
    logic                  tone;
    logic                  sym_extra;
    logic                  sym_tick;
    logic                  tb_data;
    logic                  tb_dly;
    logic                  tb_stb;
    logic                  car_lock;
    logic                  node_sync;
    logic                  sync_done;
    logic                  req_tgl;
    tsop_word_t            word;
    logic                  ack_s1;
    logic                  ack_s2;
    logic                  strm_s1;
    logic                  strm_s2;
    logic [15:0]           test_out;
  } tsop_core_t;

  typedef struct packed {
    logic              rst_s1;
    logic              rst_s2;
    logic              req_s1;
    logic              req_s2;
    logic              ack_tgl;
    logic [CFG_W-1:0]  cfg_s1;
    logic [CFG_W-1:0]  cfg_s2;
    logic              pend;
    tsop_word_t        pword;
    tsop_slot_t        phase;
    logic              bclk;
    logic [BYTE_W-1:0] data;
    logic              valid;
    logic              fstart;
    logic              strb;
    logic              err;
    logic              blk_err;
    logic [7:0]        byte_idx;
    logic [7:0]        out_idx;
    logic [2:0]        bit_idx;
    logic [BYTE_W-1:0] sh;
    logic              strm;
  } tsop_link_t;

  tsop_core_t        cst_ff;
  tsop_core_t        nxt_cst;
  tsop_link_t        lst_ff;
  tsop_link_t        nxt_lst;
  logic              core_ready;
  logic              take;
  logic              ser;
  logic              cur_err;
  logic [7:0]        cur_idx;
  logic [BYTE_W-1:0] out_byte;

  tsop_sd_if #(.W(8)) dac_if ();
  tsop_sd_if #(.W(8)) gain_if ();

  assign dac_if.level  = i_dac_level;
  assign gain_if.level = i_gain_level;

  tsop_sdm #(.W(8)) u_dac_sdm (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .sd        (dac_if)
  );

  tsop_sdm #(.W(8)) u_gain_sdm (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .sd        (gain_if)
  );

  // Word is held stable until the link side echoes the toggle back
  assign core_ready = (cst_ff.req_tgl == cst_ff.ack_s2);

  always_comb begin
    nxt_cst         = cst_ff;
    // Tone divider
    if (!i_tone_enable) begin
      nxt_cst.tone     = 1'b0;
      nxt_cst.tone_cnt = TONE_RELOAD;
    end else if (cst_ff.tone_cnt == TONE_ZERO) begin
      nxt_cst.tone     = ~cst_ff.tone;
      nxt_cst.tone_cnt = TONE_RELOAD;
    end else begin
      nxt_cst.tone_cnt = cst_ff.tone_cnt - 11'h001;
    end
    nxt_cst.sym_tick  = (i_sym_count != SYM_NONE) | cst_ff.sym_extra;
    nxt_cst.sym_extra = (i_sym_count == SYM_TWO);
    // Data one cycle ahead of the strobe edge
    nxt_cst.tb_data   = i_trellis_valid ? i_trellis_bit : cst_ff.tb_data;
    nxt_cst.tb_dly    = i_trellis_valid;
    nxt_cst.tb_stb    = cst_ff.tb_dly;
    nxt_cst.car_lock  = i_carrier_locked;
    nxt_cst.node_sync = i_node_synced;
    nxt_cst.sync_done = i_carrier_locked & i_node_synced & i_frame_locked
                        & cst_ff.strm_s2;
    if (core_ready && i_dec_valid) begin
      nxt_cst.word    = '{first: i_dec_first, parity: i_dec_parity,
                          uncorr: i_dec_uncorr, data: i_dec_byte};
      nxt_cst.req_tgl = ~cst_ff.req_tgl;
    end
    nxt_cst.ack_s1  = lst_ff.ack_tgl;
    nxt_cst.ack_s2  = cst_ff.ack_s1;
    nxt_cst.strm_s1 = lst_ff.strm;
    nxt_cst.strm_s2 = cst_ff.strm_s1;
    unique case (i_test_select)
      TSEL_STREAM: nxt_cst.test_out = {5'h00, cst_ff.word};
      TSEL_SYNC:   nxt_cst.test_out = {10'h000, cst_ff.sym_tick, cst_ff.tb_data,
                                       cst_ff.tb_stb, cst_ff.car_lock,
                                       cst_ff.node_sync, cst_ff.sync_done};
      TSEL_LEVELS: nxt_cst.test_out = {i_dac_level, i_gain_level};
      default:     nxt_cst.test_out = TEST_IDLE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cst_ff          <= '0;
      cst_ff.test_out <= nxt_cst.test_out;
    end else begin
      cst_ff <= nxt_cst;
    end
  end

  // Link side: one slot is a launch cycle and a hold cycle of the link clock
  assign ser      = lst_ff.cfg_s2[CFG_SER];
  assign take     = lst_ff.pend && (lst_ff.phase == LS_LAUNCH)
                    && (!ser || (lst_ff.bit_idx == BIT_ZERO));
  assign cur_err  = lst_ff.pword.first ? lst_ff.pword.uncorr : lst_ff.blk_err;
  assign cur_idx  = lst_ff.pword.first ? IDX_ZERO : lst_ff.byte_idx;

  always_comb begin
    out_byte = lst_ff.pword.data;
    if (cur_err && (cur_idx == TEI_BYTE_IDX)) begin
      out_byte[TEI_BIT] = 1'b1;
    end
  end

  always_comb begin
    nxt_lst        = lst_ff;
    nxt_lst.rst_s1 = i_sys_rst;
    nxt_lst.rst_s2 = lst_ff.rst_s1;
    nxt_lst.req_s1 = cst_ff.req_tgl;
    nxt_lst.req_s2 = lst_ff.req_s1;
    nxt_lst.cfg_s1 = {i_cfg_serial_valid, i_cfg_serial, i_cfg_falling};
    nxt_lst.cfg_s2 = lst_ff.cfg_s1;
    if (lst_ff.phase == LS_LAUNCH) begin
      nxt_lst.phase = LS_HOLD;
      nxt_lst.bclk  = lst_ff.cfg_s2[CFG_FALL];
      if (take) begin
        nxt_lst.valid    = ~lst_ff.pword.parity;
        nxt_lst.fstart   = lst_ff.pword.first;
        nxt_lst.err      = cur_err;
        nxt_lst.blk_err  = cur_err;
        nxt_lst.out_idx  = cur_idx;
        nxt_lst.byte_idx = (cur_idx == BLOCK_LEN_LONG) ? cur_idx : cur_idx + IDX_ONE;
        nxt_lst.strm     = lst_ff.strm | ~lst_ff.pword.parity;
        if (ser) begin
          nxt_lst.data    = {7'h00, out_byte[BYTE_W-1]};
          nxt_lst.sh      = {out_byte[BYTE_W-2:0], 1'b0};
          nxt_lst.bit_idx = BIT_ONE;
        end else begin
          nxt_lst.data = out_byte;
        end
      end else if (ser && (lst_ff.bit_idx != BIT_ZERO)) begin
        nxt_lst.data    = {7'h00, lst_ff.sh[BYTE_W-1]};
        nxt_lst.sh      = {lst_ff.sh[BYTE_W-2:0], 1'b0};
        nxt_lst.bit_idx = (lst_ff.bit_idx == BIT_LAST) ? BIT_ZERO
                                                       : lst_ff.bit_idx + BIT_ONE;
        nxt_lst.fstart  = 1'b0;
      end else begin
        nxt_lst.valid  = 1'b0;
        nxt_lst.fstart = 1'b0;
      end
      if (!ser) begin
        nxt_lst.strb = 1'b0;
      end else if (lst_ff.cfg_s2[CFG_SERV]) begin
        nxt_lst.strb = nxt_lst.valid;
      end else if (nxt_lst.valid) begin
        nxt_lst.strb = ~lst_ff.strb;
      end
    end else begin
      nxt_lst.phase = LS_LAUNCH;
      nxt_lst.bclk  = ~lst_ff.cfg_s2[CFG_FALL];
      if (!ser) begin
        nxt_lst.strb = lst_ff.valid;
      end
    end
    nxt_lst.pend = lst_ff.pend & ~take;
    if (!nxt_lst.pend && (lst_ff.req_s2 != lst_ff.ack_tgl)) begin
      nxt_lst.pend    = 1'b1;
      nxt_lst.pword   = cst_ff.word;
      nxt_lst.ack_tgl = lst_ff.req_s2;
    end
    if (lst_ff.rst_s2) begin
      nxt_lst.pend     = 1'b0;
      nxt_lst.ack_tgl  = lst_ff.req_s2;
      nxt_lst.phase    = LS_LAUNCH;
      nxt_lst.bclk     = ~lst_ff.cfg_s2[CFG_FALL];
      nxt_lst.data     = '0;
      nxt_lst.valid    = 1'b0;
      nxt_lst.fstart   = 1'b0;
      nxt_lst.strb     = 1'b0;
      nxt_lst.err      = 1'b0;
      nxt_lst.blk_err  = 1'b0;
      nxt_lst.byte_idx = IDX_ZERO;
      nxt_lst.bit_idx  = BIT_ZERO;
      nxt_lst.strm     = 1'b0;
    end
  end

  always_ff @(posedge i_link_clk) begin
    lst_ff <= nxt_lst;
  end

  assign o_dec_ready             = core_ready;
  assign o_ts_data               = lst_ff.data;
  assign o_ts_byte_clk           = lst_ff.bclk;
  assign o_ts_valid              = lst_ff.valid;
  assign o_ts_block_start        = lst_ff.fstart;
  assign o_ts_byte_strobe        = lst_ff.strb;
  assign o_ts_block_error        = lst_ff.err;
  assign o_carrier_phase_locked  = cst_ff.car_lock;
  assign o_trellis_node_synced   = cst_ff.node_sync;
  assign o_sync_done             = cst_ff.sync_done;
  assign o_symbol_tick           = cst_ff.sym_tick;
  assign o_trellis_serial_out    = cst_ff.tb_data;
  assign o_trellis_serial_strobe = cst_ff.tb_stb;
  assign o_density_dac_out       = dac_if.bit_out;
  assign o_gain_control_bit      = gain_if.bit_out;
  assign o_dish_tone_out         = cst_ff.tone;
  assign o_test                  = cst_ff.test_out;
  assign o_clk_copy              = i_clk;

  // Core domain checks
  property p_tone_edge;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_tone_enable && $changed(o_dish_tone_out)) |-> $past(cst_ff.tone_cnt) == TONE_ZERO;
  endproperty
  a_tone_edge: assert property (p_tone_edge) else $error("tone edge off divider");

  property p_sym_tick;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_sym_count != SYM_NONE) |=> o_symbol_tick;
  endproperty
  a_sym_tick: assert property (p_sym_tick) else $error("symbol tick missing");

  sequence s_two_ticks;
    o_symbol_tick ##1 o_symbol_tick;
  endsequence
  property p_sym_two;
    @(posedge i_clk) disable iff (i_sys_rst)
      (i_sym_count == SYM_TWO) |=> s_two_ticks;
  endproperty
  a_sym_two: assert property (p_sym_two) else $error("double symbol not stretched");

  property p_trellis_out;
    @(posedge i_clk) disable iff (i_sys_rst)
      i_trellis_valid |-> ##2 (o_trellis_serial_strobe
                              && o_trellis_serial_out == $past(i_trellis_bit, 2));
  endproperty
  a_trellis_out: assert property (p_trellis_out) else $error("trellis bit not strobed");

  property p_sync_done;
    @(posedge i_clk) disable iff (i_sys_rst)
      o_sync_done |-> (o_carrier_phase_locked && o_trellis_node_synced);
  endproperty
  a_sync_done: assert property (p_sync_done) else $error("sync done without locks");

  // Link domain checks
  property p_bclk_toggle;
    @(posedge i_link_clk) disable iff (lst_ff.rst_s2)
      $stable(lst_ff.cfg_s2[CFG_FALL]) |=> o_ts_byte_clk != $past(o_ts_byte_clk);
  endproperty
  a_bclk_toggle: assert property (p_bclk_toggle) else $error("byte clock stalled");

  property p_no_strobe_parity;
    @(posedge i_link_clk) disable iff (lst_ff.rst_s2)
      (!ser && !o_ts_valid) |-> !o_ts_byte_strobe;
  endproperty
  a_no_strobe_parity: assert property (p_no_strobe_parity)
    else $error("strobe active without payload");

  sequence s_pay_launch;
    !ser && o_ts_valid && !o_ts_byte_strobe;
  endsequence
  sequence s_strobe_rise;
    o_ts_byte_strobe && o_ts_valid && $stable(o_ts_data) && $stable(o_ts_block_start);
  endsequence
  property p_strobe_rise;
    @(posedge i_link_clk) disable iff (lst_ff.rst_s2)
      s_pay_launch |=> s_strobe_rise;
  endproperty
  a_strobe_rise: assert property (p_strobe_rise) else $error("strobe did not rise");

  property p_tei_set;
    @(posedge i_link_clk) disable iff (lst_ff.rst_s2)
      (!ser && o_ts_valid && o_ts_block_error && lst_ff.out_idx == TEI_BYTE_IDX)
        |-> o_ts_data[TEI_BIT];
  endproperty
  a_tei_set: assert property (p_tei_set) else $error("error bit not set in packet");

endmodule // tsop_top

// ===== tsop_ts_sink.sv
module tsop_ts_sink
  import tsop_pkg::*;
(
  // Transport stream link
  input  wire logic              i_byte_clk,
  input  wire logic              i_falling,
  input  wire logic [BYTE_W-1:0] i_data,
  input  wire logic              i_valid,
  input  wire logic              i_start,
  input  wire logic              i_error,
  input  wire logic              i_strobe,
  // Trellis tap
  input  wire logic              i_tb_bit,
  input  wire logic              i_tb_strobe,
  // Capture results
  output int                     o_strobe_rises,
  output int                     o_clk_rises,
  output int                     o_tb_count,
  output logic                   o_tb_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Error, start and data of every valid slot taken (one per byte, or one per bit in serial mode)
  logic [9:0] words[$];

  task automatic take();
    if (i_valid === 1'b1) begin
      words.push_back({i_error, i_start, i_data});
    end
  endtask

  initial begin
    o_strobe_rises = 0;
    o_clk_rises = 0;
    o_tb_count = 0;
  end

  always @(posedge i_byte_clk) begin
    o_clk_rises++;
    if (!i_falling) take();
  end

  always @(negedge i_byte_clk) begin
    if (i_falling) take();
  end

  always @(posedge i_strobe) o_strobe_rises++;

  // Bit taken only on the strobe's rising edge
  always @(posedge i_tb_strobe) begin
    o_tb_bit <= i_tb_bit;
    o_tb_count++;
  end
endmodule // tsop_ts_sink

// ===== tb_tsop_top.sv
module tb_tsop_top
  import tsop_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, lclk, dv, dfirst, dpar, dunc, fall, car, node, frame, tbit, tval;
  logic        rdy, bclk, tvalid, tstart, tstrb, terr, car_o, node_o, done, tick, tser, tstb;
  logic        tone, dsd, agc, tone_o, ccopy, tb_seen, b, ser_on, ser_hold, lastb;
  logic [7:0]  dbyte, dac, gain, tsel, tdata, lvl;
  logic [1:0]  sym;
  logic [15:0] test_o;
  logic [10:0] last_w;
  logic [9:0]  exp_q[$];
  int          errors, checks, cycles, srise, crise, tcnt, n, m, t0;

  tsop_top tsop_top_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_link_clk(lclk),
    .i_dec_byte(dbyte), .i_dec_valid(dv), .i_dec_first(dfirst), .i_dec_parity(dpar),
    .i_dec_uncorr(dunc), .o_dec_ready(rdy),
    .i_cfg_falling(fall), .i_cfg_serial(ser_on), .i_cfg_serial_valid(ser_hold),
    .i_carrier_locked(car), .i_node_synced(node), .i_frame_locked(frame), .i_sym_count(sym),
    .i_trellis_bit(tbit), .i_trellis_valid(tval), .i_dac_level(dac), .i_gain_level(gain),
    .i_tone_enable(tone), .i_test_select(tsel),
    .o_ts_data(tdata), .o_ts_byte_clk(bclk), .o_ts_valid(tvalid), .o_ts_block_start(tstart),
    .o_ts_byte_strobe(tstrb), .o_ts_block_error(terr), .o_carrier_phase_locked(car_o),
    .o_trellis_node_synced(node_o), .o_sync_done(done), .o_symbol_tick(tick),
    .o_trellis_serial_out(tser), .o_trellis_serial_strobe(tstb), .o_density_dac_out(dsd),
    .o_gain_control_bit(agc), .o_dish_tone_out(tone_o), .o_test(test_o), .o_clk_copy(ccopy)
  );

  tsop_ts_sink tsop_ts_sink_inst (
    .i_byte_clk(bclk), .i_falling(fall), .i_data(tdata), .i_valid(tvalid),
    .i_start(tstart), .i_error(terr), .i_strobe(tstrb), .i_tb_bit(tser), .i_tb_strobe(tstb),
    .o_strobe_rises(srise), .o_clk_rises(crise), .o_tb_count(tcnt), .o_tb_bit(tb_seen)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Link clock offset so its edges never line up with the core clock
  initial begin
    lclk = 1'b0;
    #7;
    forever #15 lclk = ~lclk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  function automatic logic [9:0] exp_word(logic [7:0] d, int idx, logic unc);
    return {unc, idx == 0, (idx == 1 && unc) ? (d | 8'h80) : d};
  endfunction

  function automatic logic near(int cnt, logic [7:0] l);
    return cnt >= int'(l) - 1 && cnt <= int'(l) + 1;
  endfunction

  function automatic logic [15:0] exp_test(logic [7:0] s);
    case (s)
      TSEL_STREAM: return {5'h00, last_w};
      TSEL_SYNC:   return {10'h000, 1'b0, lastb, 1'b0, car, node, car & node & frame};
      TSEL_LEVELS: return {dac, gain};
      default:     return TEST_IDLE;
    endcase
  endfunction

  // Source holds the offer until it sees ready, so refusals lose nothing
  task automatic send_byte(logic [7:0] d, logic first, logic par, logic unc);
    int k;
    k = 0;
    dbyte <= d;
    dfirst <= first;
    dpar <= par;
    dunc <= unc;
    dv <= 1'b1;
    last_w = {first, par, unc, d};
    do begin
      @(negedge clk);
      k++;
    end while (rdy !== 1'b1 && k < 100);
    // Valid stays up between bytes; the caller drops it after the last one
    @(posedge clk);
  endtask

  task automatic send_block(int len, logic unc, int mode);
    int s0, c0, nw, nst;
    logic [7:0] d;
    logic [9:0] w;
    exp_q.delete();
    tsop_ts_sink_inst.words.delete();
    s0 = srise;
    c0 = crise;
    // Serial: eight slots per byte; hold mode strobes once per unbroken run
    nw = (mode == 0) ? len : 8 * len;
    nst = (mode == 0) ? len : (mode == 1) ? 4 * len : 1;
    for (int i = 0; i < len + PARITY_BYTES; i++) begin
      d = 8'($urandom());
      send_byte(d, i == 0, i >= len, unc && i == 0);
      w = exp_word(d, i, unc);
      if (i < len && mode == 0) begin
        exp_q.push_back(w);
      end else if (i < len) begin
        for (int j = 7; j >= 0; j--) begin
          exp_q.push_back({w[9], w[8] && (j == 7), 7'h00, w[j]});
        end
      end
    end
    dv <= 1'b0;
    repeat (40) @(posedge clk);
    check(32'(tsop_ts_sink_inst.words.size()), 32'(nw), "payload count");
    foreach (exp_q[i]) check(32'(tsop_ts_sink_inst.words[i]), 32'(exp_q[i]), "word");
    check(32'(srise - s0), 32'(nst), "strobes");
    check(32'(crise - c0 >= len + PARITY_BYTES), 32'h1, "byte clock");
    $display("test block of %0d done", len);
  endtask

  initial begin
    void'($urandom(32'hB6CE));
    {rst, dv, dfirst, dpar, dunc, fall, tbit, tval, tone, car, node, frame} = 12'h80F;
    {dbyte, sym, ser_on, ser_hold} = 12'h000;
    {dac, gain, tsel} = {8'h5A, 8'hC3, TSEL_LEVELS};
    // Held long enough for the link side's two-stage reset
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(32'(test_o), 32'({dac, gain}), "test in reset");
    @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    send_block(int'(BLOCK_LEN_LONG), 1'b0, 0);
    fall <= 1'b1;
    repeat (20) @(posedge clk);
    send_block(int'(BLOCK_LEN_SHORT), 1'b1, 0);
    ser_on <= 1'b1;
    repeat (20) @(posedge clk);
    send_block(int'(BLOCK_LEN_SHORT), 1'b1, 1);
    ser_hold <= 1'b1;
    repeat (20) @(posedge clk);
    send_block(int'(BLOCK_LEN_SHORT), 1'b0, 2);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      car <= (k == 0) | 1'($urandom());
      node <= (k == 0) | 1'($urandom());
      frame <= (k != 1) & 1'($urandom());
      repeat (4) @(negedge clk);
      check(32'(car_o), 32'(car), "carrier");
      check(32'(node_o), 32'(node), "node");
      check(32'(done), 32'(car & node & frame), "sync done");
    end
    $display("test status done");
    for (int k = 1; k <= 2; k++) begin
      @(posedge clk);
      sym <= 2'(k);
      @(posedge clk);
      sym <= SYM_NONE;
      n = 0;
      repeat (6) begin
        @(negedge clk);
        n += int'(tick === 1'b1);
      end
      check(32'(n), 32'(k), "tick");
    end
    t0 = tcnt;
    repeat (8) begin
      @(posedge clk);
      b = 1'($urandom());
      tbit <= b;
      tval <= 1'b1;
      @(posedge clk);
      tval <= 1'b0;
      tbit <= ~b;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(32'(tb_seen), 32'(b), "trellis bit");
    end
    lastb = b;
    check(32'(tcnt - t0), 32'h8, "trellis strobes");
    $display("test symbol and trellis done");
    for (int r = 0; r < 2; r++) begin
      b = tone_o;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (tone_o === b && n < 3000);
    end
    check(32'(n), 32'(TONE_HALF_CYC), "tone half period");
    @(posedge clk);
    tone <= 1'b0;
    repeat (3) @(negedge clk);
    check(32'(tone_o), 32'h0, "tone off");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      lvl = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom());
      dac <= lvl;
      gain <= ~lvl;
      repeat (20) @(posedge clk);
      n = 0;
      m = 0;
      repeat (256) begin
        @(negedge clk);
        n += int'(dsd === 1'b1);
        m += int'(agc === 1'b1);
      end
      check(32'(near(n, lvl)), 32'h1, "dac density");
      check(32'(near(m, ~lvl)), 32'h1, "gain density");
    end
    for (int k = 0; k < 6; k++) begin
      @(posedge clk);
      lvl = (k == 0) ? 8'h00 : (k == 1) ? TSEL_LEVELS : (k == 2) ? 8'h04 : 8'hFF;
      lvl = (k == 3) ? TSEL_STREAM : (k == 4) ? TSEL_SYNC : lvl;
      tsel <= lvl;
      repeat (3) @(negedge clk);
      check(32'(test_o), 32'(exp_test(lvl)), "test select");
    end
    @(negedge clk);
    #1 check(32'(ccopy), 32'(clk), "clock copy low");
    @(posedge clk);
    #1 check(32'(ccopy), 32'(clk), "clock copy high");
    $display("test analog and test pins done");
    @(posedge clk);
    rst <= 1'b1;
    tsel <= TSEL_LEVELS;
    dac <= 8'($urandom());
    repeat (10) @(posedge clk);
    @(negedge clk);
    check(32'(test_o), 32'({dac, gain}), "test held in reset");
    check(32'(done), 32'h0, "sync done in reset");
    check(32'(tvalid), 32'h0, "valid in reset");
    @(posedge clk);
    rst <= 1'b0;
    fall <= 1'b0;
    ser_on <= 1'b0;
    ser_hold <= 1'b0;
    repeat (10) @(posedge clk);
    send_block(int'(BLOCK_LEN_SHORT), 1'b0, 0);
    complete_run();
  end
endmodule // tb_tsop_top
